// >>> tmc_pkg.sv
// package: register map, field layout and timing constants of the timer pair
package tmc_pkg;
  localparam logic [7:0] TMC_ADDR_CONTROL  = 8'h88;
  localparam logic [7:0] TMC_ADDR_MODE     = 8'h89;
  localparam logic [7:0] TMC_ADDR_LOW0     = 8'h8A;
  localparam logic [7:0] TMC_ADDR_LOW1     = 8'h8B;
  localparam logic [7:0] TMC_ADDR_HIGH0    = 8'h8C;
  localparam logic [7:0] TMC_ADDR_HIGH1    = 8'h8D;
  localparam logic [7:0] TMC_ADDR_CLKCTL   = 8'h8F;
  localparam logic [7:0] TMC_ADDR_SCHED    = 8'h90;
  // control register bit positions
  localparam int TMC_CTL_ITYPE0 = 0;
  localparam int TMC_CTL_IFLAG0 = 1;
  localparam int TMC_CTL_ITYPE1 = 2;
  localparam int TMC_CTL_IFLAG1 = 3;
  localparam int TMC_CTL_RUN0   = 4;
  localparam int TMC_CTL_OVF0   = 5;
  localparam int TMC_CTL_RUN1   = 6;
  localparam int TMC_CTL_OVF1   = 7;
  // mode register nibble positions
  localparam int TMC_MODE_T0_LSB = 0;
  localparam int TMC_MODE_T1_LSB = 4;
  // clock control and scheduler register fields
  localparam int TMC_CLK_SEL0   = 0;
  localparam int TMC_CLK_SEL1   = 1;
  localparam int TMC_SCHED_LSB  = 0;
  localparam logic [7:0] TMC_RESET_BYTE = 8'h00;
  // timer clock periods per peripheral cycle, and prescaler width in mode 0
  localparam int TMC_PER_CYCLE  = 6;
  localparam logic [2:0] TMC_PER_LAST = 3'(TMC_PER_CYCLE - 1);
  localparam int TMC_PRESC_BITS = 5;
  localparam int TMC_ODIV_BITS  = 7;

  typedef enum logic [1:0] {
    TMC_M13BIT  = 2'b00,
    TMC_M16BIT  = 2'b01,
    TMC_MRELOAD = 2'b10,
    TMC_MSPLIT  = 2'b11
  } tmc_mode_t;

  typedef struct packed {
    logic      gate_enable;
    logic      counter_sel;
    tmc_mode_t mode_sel;
  } tmc_tctl_t;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
    logic       ovf;
  } tmc_step_t;
endpackage

// >>> tmc_timer_pair.sv
// two 16-bit timer/counters with register port, gating and overflow divider
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/100ps
// Summary of operation
// RULE_01: run bit lets selected input bump low byte, carry into high byte, then flag
// RULE_02: setting run bit keeps the count registers as they are
// RULE_03: software stops a timer before presetting its count registers
// RULE_04: timer mode counts once per peripheral cycle of six timer clocks
// RULE_05: counter mode samples pin each peripheral cycle, counts a high-then-low pair
// RULE_06: external count level should last at least one peripheral cycle
// RULE_07: timer clock is oscillator/2 when selected, else /2 or /1 by speed mode
// RULE_08: gate bit clear lets run bit alone enable; set adds gate pin level
// RULE_09: gated timer counts only while gate pin high and run bit set
// RULE_10: rollover from all ones to zeros sets the overflow flag
// RULE_11: two mode bits pick 13-bit, 16-bit, 8-bit reload or mode 3
// RULE_12: mode 0 uses five low bits as modulo-32 prescaler into high byte
// RULE_13: mode 2 reloads low byte from unchanged high byte and sets flag
// RULE_14: servicing the interrupt clears the overflow flag
// RULE_15: timer 0 mode 3 splits into two 8-bit timers, high uses timer 1 bits
// RULE_16: timer 0 overflow divider divides flag rate by 2 to 128, code 0 off
// RULE_17: timer 1 has no divider; its modes 0 to 2 match timer 0
// RULE_18: timer 1 in mode 3 stops and holds its count
// RULE_19: timer 0 uses mode bits 3:0 and control bits 0,1,4,5
// RULE_20: timer 1 uses mode bits 7:4 and control bits 2,3,6,7
// RULE_21: with timer 0 in mode 3, timer 1 runs unless in mode 3, no flag
// RULE_22: software stops a timer before changing selection or mode
// RULE_23: timer 1 overflow drives the serial port baud tick
// RULE_24: count pins get two-stage synchroniser; flag set beats clear
// RULE_25: software count write lands next cycle and beats hardware update
module tmc_timer_pair
  import tmc_pkg::*;
(
  input  wire logic       SYS_CLK,       // 20 MHz oscillator clock
  input  wire logic       RST_B,         // synchronous reset, active low
  input  wire logic [7:0] ADDR,          // register address
  input  wire logic [7:0] WDATA,         // write data
  input  wire logic       WR,            // write strobe
  input  wire logic       RD,            // read strobe
  output logic      [7:0] RDATA,         // read data, cycle after RD
  input  wire logic       DOUBLE_SPEED,  // double speed clock mode
  input  wire logic       COUNT_PIN_0,   // external count input, timer 0
  input  wire logic       COUNT_PIN_1,   // external count input, timer 1
  input  wire logic       GATE_PIN_0,    // external gate level, timer 0
  input  wire logic       GATE_PIN_1,    // external gate level, timer 1
  input  wire logic       IRQ_ACK_0,     // interrupt serviced, timer 0
  input  wire logic       IRQ_ACK_1,     // interrupt serviced, timer 1
  output logic            OVF_FLAG_0,    // overflow flag / request, timer 0
  output logic            OVF_FLAG_1,    // overflow flag / request, timer 1
  output logic            BAUD_TICK      // timer 1 overflow pulse to serial port
);

  logic [7:0] ctl_q, ctl_d, mode_q, mode_d, clk_q, clk_d, sched_q, sched_d;
  logic [7:0] low0_q, low0_d, low1_q, low1_d, high0_q, high0_d, high1_q, high1_d;
  logic [7:0] rdata_q, rdata_d;
  logic       div2_q, div2_d, baud_q, baud_d;
  logic [2:0] pcnt0_q, pcnt0_d, pcnt1_q, pcnt1_d;
  logic [1:0] sync0_q, sync0_d, sync1_q, sync1_d;
  logic       samp0_q, samp0_d, samp1_q, samp1_d;
  logic [TMC_ODIV_BITS-1:0] odiv_q, odiv_d;

  tmc_tctl_t  tc0, tc1;
  logic       tclk0, tclk1, tick0, tick1, edge0, edge1, inc0, inc1, en0, en1;
  logic       t0_split, split_inc, ovf0_evt, ovf1_evt, flag0_set, flag1_set;
  logic       wr_low0, wr_low1, wr_high0, wr_high1, wr_ctl;
  logic [2:0] odiv_code;
  tmc_step_t  st0, st1;

  // one counting step for the low/high pair in modes 0, 1, 2 and split low half
  function automatic tmc_step_t count_step(input tmc_mode_t m, input logic [7:0] lo,
                                           input logic [7:0] hi);
    tmc_step_t r;
    logic [TMC_PRESC_BITS:0] pre;
    logic [8:0] lsum, hsum;
    r    = '{high: hi, low: lo, ovf: 1'b0};
    pre  = {1'b0, lo[TMC_PRESC_BITS-1:0]} + 6'h01;
    lsum = {1'b0, lo} + 9'h001;
    hsum = {1'b0, hi} + 9'h001;
    case (m)
      TMC_M13BIT: begin
        // upper three low bits are left alone and carry no meaning
        r.low[TMC_PRESC_BITS-1:0] = pre[TMC_PRESC_BITS-1:0]; // RULE_12
        if (pre[TMC_PRESC_BITS]) begin
          r.high = hsum[7:0];
          r.ovf  = hsum[8];
        end
      end
      TMC_M16BIT: begin
        r.low = lsum[7:0]; // RULE_01
        if (lsum[8]) begin
          r.high = hsum[7:0];
          r.ovf  = hsum[8]; // RULE_10
        end
      end
      TMC_MRELOAD: begin
        r.low = lsum[8] ? hi : lsum[7:0]; // RULE_13
        r.ovf = lsum[8];
      end
      default: begin
        r.low = lsum[7:0];
        r.ovf = lsum[8];
      end
    endcase
    return r;
  endfunction

  always_comb begin
    tc0       = tmc_tctl_t'(mode_q[TMC_MODE_T0_LSB +: 4]); // RULE_19
    tc1       = tmc_tctl_t'(mode_q[TMC_MODE_T1_LSB +: 4]); // RULE_20
    t0_split  = (tc0.mode_sel == TMC_MSPLIT);
    odiv_code = sched_q[TMC_SCHED_LSB +: 3];
    // timer clock enables: oscillator/2 unless double speed and clock select clear
    tclk0 = (clk_q[TMC_CLK_SEL0] || !DOUBLE_SPEED) ? div2_q : 1'b1; // RULE_07
    tclk1 = (clk_q[TMC_CLK_SEL1] || !DOUBLE_SPEED) ? div2_q : 1'b1; // RULE_07
    tick0 = tclk0 && (pcnt0_q == TMC_PER_LAST); // RULE_04
    tick1 = tclk1 && (pcnt1_q == TMC_PER_LAST); // RULE_04
    // only the second synchroniser stage and the held sample are looked at
    edge0 = tick0 && samp0_q && !sync0_q[1]; // RULE_05
    edge1 = tick1 && samp1_q && !sync1_q[1]; // RULE_05
    en0   = ctl_q[TMC_CTL_RUN0] && (!tc0.gate_enable || GATE_PIN_0); // RULE_08 RULE_09
    en1   = t0_split ? 1'b1 // RULE_21
                     : ctl_q[TMC_CTL_RUN1] && (!tc1.gate_enable || GATE_PIN_1); // RULE_08
    inc0  = en0 && (tc0.counter_sel ? edge0 : tick0);
    inc1  = en1 && (tc1.mode_sel != TMC_MSPLIT) // RULE_18
                && (tc1.counter_sel ? edge1 : tick1); // RULE_17
    split_inc = t0_split && ctl_q[TMC_CTL_RUN1] && tick0; // RULE_15
    st0   = count_step(tc0.mode_sel, low0_q, high0_q); // RULE_11
    st1   = count_step(tc1.mode_sel, low1_q, high1_q); // RULE_17
    if (t0_split) begin
      st0.high = high0_q + 8'h01; // RULE_15
    end
    ovf0_evt = inc0 && st0.ovf;
    ovf1_evt = inc1 && st1.ovf;

    wr_ctl   = WR && (ADDR == TMC_ADDR_CONTROL);
    wr_low0  = WR && (ADDR == TMC_ADDR_LOW0);
    wr_low1  = WR && (ADDR == TMC_ADDR_LOW1);
    wr_high0 = WR && (ADDR == TMC_ADDR_HIGH0);
    wr_high1 = WR && (ADDR == TMC_ADDR_HIGH1);

    div2_d  = !div2_q;
    pcnt0_d = !tclk0 ? pcnt0_q : (pcnt0_q == TMC_PER_LAST) ? 3'h0 : pcnt0_q + 3'h1;
    pcnt1_d = !tclk1 ? pcnt1_q : (pcnt1_q == TMC_PER_LAST) ? 3'h0 : pcnt1_q + 3'h1;
    sync0_d = {sync0_q[0], COUNT_PIN_0}; // RULE_24
    sync1_d = {sync1_q[0], COUNT_PIN_1}; // RULE_24
    samp0_d = tick0 ? sync0_q[1] : samp0_q;
    samp1_d = tick1 ? sync1_q[1] : samp1_q;

    // overflow divider: code n passes one event in 2**n
    odiv_d    = odiv_q;
    flag0_set = 1'b0;
    if (ovf0_evt) begin
      if (odiv_code == 3'h0) begin
        flag0_set = 1'b1; // RULE_16
      end else if (odiv_q >= TMC_ODIV_BITS'((1 << odiv_code) - 1)) begin
        flag0_set = 1'b1; // RULE_16
        odiv_d    = '0;
      end else begin
        odiv_d = odiv_q + 7'h01;
      end
    end
    // in split mode the high half owns timer 1 flag; timer 1 then raises none
    flag1_set = t0_split ? (split_inc && (high0_q == 8'hFF)) : ovf1_evt; // RULE_21
    baud_d    = ovf1_evt; // RULE_23

    // count registers: a software write beats the hardware step
    low0_d  = wr_low0  ? WDATA : inc0 ? st0.low : low0_q; // RULE_25
    high0_d = wr_high0 ? WDATA
            : (t0_split ? split_inc : inc0) ? st0.high : high0_q; // RULE_25
    low1_d  = wr_low1  ? WDATA : inc1 ? st1.low : low1_q; // RULE_25
    high1_d = wr_high1 ? WDATA : inc1 ? st1.high : high1_q; // RULE_25

    ctl_d   = wr_ctl ? WDATA : ctl_q; // RULE_02
    if (IRQ_ACK_0) begin
      ctl_d[TMC_CTL_OVF0] = 1'b0; // RULE_14
    end
    if (IRQ_ACK_1) begin
      ctl_d[TMC_CTL_OVF1] = 1'b0; // RULE_14
    end
    if (flag0_set) begin
      ctl_d[TMC_CTL_OVF0] = 1'b1; // RULE_24
    end
    if (flag1_set) begin
      ctl_d[TMC_CTL_OVF1] = 1'b1; // RULE_24
    end
    mode_d  = (WR && ADDR == TMC_ADDR_MODE)   ? WDATA : mode_q;
    clk_d   = (WR && ADDR == TMC_ADDR_CLKCTL) ? WDATA : clk_q;
    sched_d = (WR && ADDR == TMC_ADDR_SCHED)  ? WDATA : sched_q;

    rdata_d = TMC_RESET_BYTE;
    if (RD) begin
      case (ADDR)
        TMC_ADDR_CONTROL: rdata_d = ctl_q;
        TMC_ADDR_MODE:    rdata_d = mode_q;
        TMC_ADDR_LOW0:    rdata_d = low0_q;
        TMC_ADDR_LOW1:    rdata_d = low1_q;
        TMC_ADDR_HIGH0:   rdata_d = high0_q;
        TMC_ADDR_HIGH1:   rdata_d = high1_q;
        TMC_ADDR_CLKCTL:  rdata_d = {6'h00, clk_q[1:0]};
        TMC_ADDR_SCHED:   rdata_d = {5'h00, sched_q[2:0]};
        default:          rdata_d = TMC_RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      ctl_q   <= TMC_RESET_BYTE;
      mode_q  <= TMC_RESET_BYTE;
      clk_q   <= TMC_RESET_BYTE;
      sched_q <= TMC_RESET_BYTE;
      low0_q  <= TMC_RESET_BYTE;
      low1_q  <= TMC_RESET_BYTE;
      high0_q <= TMC_RESET_BYTE;
      high1_q <= TMC_RESET_BYTE;
      rdata_q <= TMC_RESET_BYTE;
      div2_q  <= 1'b0;
      baud_q  <= 1'b0;
      pcnt0_q <= 3'h0;
      pcnt1_q <= 3'h0;
      sync0_q <= 2'h0;
      sync1_q <= 2'h0;
      samp0_q <= 1'b0;
      samp1_q <= 1'b0;
      odiv_q  <= '0;
    end else begin
      ctl_q   <= ctl_d;
      mode_q  <= mode_d;
      clk_q   <= clk_d;
      sched_q <= sched_d;
      low0_q  <= low0_d;
      low1_q  <= low1_d;
      high0_q <= high0_d;
      high1_q <= high1_d;
      rdata_q <= rdata_d;
      div2_q  <= div2_d;
      baud_q  <= baud_d;
      pcnt0_q <= pcnt0_d;
      pcnt1_q <= pcnt1_d;
      sync0_q <= sync0_d;
      sync1_q <= sync1_d;
      samp0_q <= samp0_d;
      samp1_q <= samp1_d;
      odiv_q  <= odiv_d;
    end
  end

  assign RDATA      = rdata_q;
  assign OVF_FLAG_0 = ctl_q[TMC_CTL_OVF0];
  assign OVF_FLAG_1 = ctl_q[TMC_CTL_OVF1];
  assign BAUD_TICK  = baud_q;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);

  // the phase counter is three bits wide, so longer peripheral cycles cannot be served
  if (TMC_PER_CYCLE < 2 || TMC_PER_CYCLE > 8) begin : g_per_chk
    $error("peripheral cycle length does not fit the phase counter");
  end
  if (TMC_PRESC_BITS < 1 || TMC_PRESC_BITS > 7) begin : g_presc_chk
    $error("prescaler must leave room in the low byte");
  end

  sequence s_t0_wrap;
    inc0 && tc0.mode_sel == TMC_M16BIT && low0_q == 8'hFF && high0_q == 8'hFF
    && !wr_low0 && !wr_high0;
  endsequence

  // timer 1 full 16-bit rollover, only while it owns its own flag
  sequence s_t1_wrap;
    inc1 && !t0_split && tc1.mode_sel == TMC_M16BIT && low1_q == 8'hFF && high1_q == 8'hFF
    && !wr_low1 && !wr_high1;
  endsequence

  // split high half about to roll over
  sequence s_split_top;
    split_inc && high0_q == 8'hFF;
  endsequence

  count_hold_a: assert property ( // RULE_02
    !inc0 && !split_inc && !wr_low0 && !wr_high0 |=> $stable(low0_q) && $stable(high0_q))
    else $error("timer 0 count moved while disabled");
  wrap_flag_a: assert property ( // RULE_10
    s_t0_wrap ##0 (odiv_code == 3'h0) |=> OVF_FLAG_0 && low0_q == 8'h00 && high0_q == 8'h00)
    else $error("timer 0 rollover did not set flag");
  set_beats_ack_a: assert property ( // RULE_24
    flag1_set && IRQ_ACK_1 |=> OVF_FLAG_1)
    else $error("flag set lost against clear");
  ack_clear_a: assert property ( // RULE_14
    IRQ_ACK_0 && !flag0_set && !(wr_ctl && WDATA[TMC_CTL_OVF0]) |=> !OVF_FLAG_0)
    else $error("service did not clear timer 0 flag");
  t1_halt_a: assert property ( // RULE_18
    tc1.mode_sel == TMC_MSPLIT && !wr_low1 && !wr_high1 |=> $stable(low1_q) && $stable(high1_q))
    else $error("timer 1 counted in mode 3");
  reload_a: assert property ( // RULE_13
    inc0 && tc0.mode_sel == TMC_MRELOAD && low0_q == 8'hFF && !wr_low0 && !wr_high0
    |=> low0_q == $past(high0_q) && high0_q == $past(high0_q))
    else $error("mode 2 reload wrong");
  tick_space_a: assert property ( // RULE_04
    tick0 |=> !tick0 [*5])
    else $error("peripheral ticks closer than six clocks");
  write_wins_a: assert property ( // RULE_25
    wr_low1 |=> low1_q == $past(WDATA))
    else $error("count write did not land");
  baud_out_a: assert property ( // RULE_23
    ovf1_evt |=> BAUD_TICK ##1 !BAUD_TICK || ovf1_evt)
    else $error("baud tick missing");
  read_back_a: assert property ( // RULE_19
    RD && ADDR == TMC_ADDR_MODE |=> RDATA == $past(mode_q))
    else $error("mode register read wrong");

  // read port quiet outside the answer cycle
  rdata_idle_a: assert property (
    !RD |=> RDATA == 8'h00)
    else $error("read data not zero outside answer cycle");
  write_high_a: assert property ( // RULE_25
    wr_high0
    |=> high0_q == $past(WDATA))
    else $error("high byte write did not land");
  t1_wrap_a: assert property ( // RULE_17
    s_t1_wrap
    |=> OVF_FLAG_1 && low1_q == 8'h00 && high1_q == 8'h00)
    else $error("timer 1 rollover did not set flag");
  t1_reload_a: assert property ( // RULE_17
    inc1 && tc1.mode_sel == TMC_MRELOAD && low1_q == 8'hFF && !wr_low1 && !wr_high1
    |=> low1_q == $past(high1_q) && $stable(high1_q))
    else $error("timer 1 reload wrong");
  presc_carry_a: assert property ( // RULE_12
    inc0 && tc0.mode_sel == TMC_M13BIT && low0_q[4:0] == 5'h1F && !wr_low0 && !wr_high0
    |=> high0_q == $past(high0_q) + 8'h01 && low0_q[4:0] == 5'h00
        && low0_q[7:5] == $past(low0_q[7:5]))
    else $error("prescaler carry wrong");
  split_high_a: assert property ( // RULE_15
    split_inc && !wr_high0
    |=> high0_q == $past(high0_q) + 8'h01)
    else $error("split high half did not count");
  split_flag_a: assert property ( // RULE_15
    s_split_top
    |=> OVF_FLAG_1)
    else $error("split high half did not raise timer 1 flag");
  no_t1_flag_a: assert property ( // RULE_21
    t0_split && !split_inc && !OVF_FLAG_1 && !(wr_ctl && WDATA[TMC_CTL_OVF1])
    |=> !OVF_FLAG_1)
    else $error("timer 1 raised its flag while split");
  gate_hold_a: assert property ( // RULE_09
    tc0.gate_enable && !GATE_PIN_0
    |-> !inc0)
    else $error("timer 0 counted with gate pin low");
  gate_enable_1_hold_a: assert property ( // RULE_09
    !t0_split && tc1.gate_enable && !GATE_PIN_1
    |-> !inc1)
    else $error("timer 1 counted with gate pin low");
  run_off_a: assert property ( // RULE_08
    !ctl_q[TMC_CTL_RUN0]
    |-> !inc0)
    else $error("timer 0 counted with run bit clear");
  t1_run_off_a: assert property ( // RULE_08
    !t0_split && !ctl_q[TMC_CTL_RUN1]
    |-> !inc1)
    else $error("timer 1 counted with run bit clear");
  edge_need_a: assert property ( // RULE_05
    tc0.counter_sel && inc0
    |-> samp0_q && !sync0_q[1] && tick0)
    else $error("counter stepped without a falling edge");
  tick_slow_a: assert property ( // RULE_07
    tick1 && clk_q[TMC_CLK_SEL1]
    |=> !tick1 [*8] ##1 !tick1 [*3])
    else $error("selected timer clock not halved");
  baud_pulse_a: assert property ( // RULE_23
    BAUD_TICK
    |=> !BAUD_TICK)
    else $error("baud tick longer than one cycle");
  div_block_a: assert property ( // RULE_16
    ovf0_evt && odiv_code != 3'h0 && odiv_q == 7'h00 && !OVF_FLAG_0
    && !(wr_ctl && WDATA[TMC_CTL_OVF0])
    |=> !OVF_FLAG_0)
    else $error("divider passed an overflow too early");
endmodule // tmc_timer_pair

// >>> tmc_timer_pair_tb.sv
// self-checking testbench for the timer pair, driven through its register port
`timescale 1ns/100ps
module tmc_timer_pair_tb
  import tmc_pkg::*;
  ;
  logic       sys_clk = 1'b0;
  logic       rst_b   = 1'b0;
  logic       wr_s    = 1'b0;
  logic       rd_s    = 1'b0;
  logic       dbl     = 1'b0;
  logic       cnt0    = 1'b0;
  logic       cnt1    = 1'b0;
  logic       gt0     = 1'b0;
  logic       gt1     = 1'b0;
  logic       ack0    = 1'b0;
  logic       ack1    = 1'b0;
  logic [7:0] addr    = 8'h00;
  logic [7:0] wdata   = 8'h00;
  logic [7:0] rdata;
  logic       ovf0;
  logic       ovf1;
  logic       baud;
  logic [7:0] d;
  int         n;
  int         err_count  = 0;
  int         num_checks = 0;
  int         cyc        = 0;
  logic [7:0] regs [9] = '{TMC_ADDR_CONTROL, TMC_ADDR_MODE, TMC_ADDR_LOW0, TMC_ADDR_LOW1,
                           TMC_ADDR_HIGH0, TMC_ADDR_HIGH1, TMC_ADDR_CLKCTL, TMC_ADDR_SCHED, 8'h8E};

  tmc_timer_pair dut_u (.SYS_CLK(sys_clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata),
    .WR(wr_s), .RD(rd_s), .RDATA(rdata), .DOUBLE_SPEED(dbl), .COUNT_PIN_0(cnt0),
    .COUNT_PIN_1(cnt1), .GATE_PIN_0(gt0), .GATE_PIN_1(gt1), .IRQ_ACK_0(ack0),
    .IRQ_ACK_1(ack1), .OVF_FLAG_0(ovf0), .OVF_FLAG_1(ovf1), .BAUD_TICK(baud));

  always #25 sys_clk = ~sys_clk;

  task automatic give_verdict;
    if (err_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // longest run is the divider sweep, well under this ceiling
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      $display("Error timeout expected done seen running");
      give_verdict();
    end
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= v;
    wr_s  <= 1'b1;
    @(posedge sys_clk);
    wr_s  <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge sys_clk);
    rd_s <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic rdc(input string name, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk(name, {8'h00, exp}, {8'h00, v});
  endtask

  task automatic ack(input int t);
    @(posedge sys_clk);
    if (t == 0) ack0 <= 1'b1;
    else ack1 <= 1'b1;
    @(posedge sys_clk);
    ack0 <= 1'b0;
    ack1 <= 1'b0;
  endtask

  // cycles until flag 0, flag 1 or baud tick (which = 0, 1, 2) is seen high
  task automatic wait_sig(input int which, input int lim, output int cnt);
    logic s;
    cnt = 0;
    do begin
      @(posedge sys_clk);
      #1;
      cnt++;
      s = (which == 0) ? ovf0 : (which == 1) ? ovf1 : baud;
    end while (s !== 1'b1 && cnt < lim);
    if (s !== 1'b1) begin
      err_count++;
      $display("Error wait %0d expected 1 seen %b", which, s);
    end
  endtask

  initial begin
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    foreach (regs[i]) rdc("reset value", regs[i], 8'h00);
    wr(8'h8E, 8'hFF);
    rdc("unmapped", 8'h8E, 8'h00);
    wr(TMC_ADDR_CONTROL, 8'h0F);
    rdc("control bits", TMC_ADDR_CONTROL, 8'h0F);
    wr(TMC_ADDR_MODE, 8'hA5);
    rdc("mode bits", TMC_ADDR_MODE, 8'hA5);
    wr(TMC_ADDR_CONTROL, 8'h00);
    // gated: pin low holds the count, pin high lets it run
    wr(TMC_ADDR_MODE, 8'h09);
    wr(TMC_ADDR_LOW0, 8'h40);
    wr(TMC_ADDR_HIGH0, 8'h00);
    wr(TMC_ADDR_CONTROL, 8'h10);
    repeat (40) @(posedge sys_clk);
    rdc("gated hold", TMC_ADDR_LOW0, 8'h40);
    @(posedge sys_clk) gt0 <= 1'b1;
    repeat (40) @(posedge sys_clk);
    wr(TMC_ADDR_CONTROL, 8'h00);
    rd(TMC_ADDR_LOW0, d);
    chk("gated run", 16'h0001, {15'h0000, d > 8'h41});
    @(posedge sys_clk) gt0 <= 1'b0;
    // 16-bit rollover with gate bit clear and gate pin low
    wr(TMC_ADDR_MODE, 8'h01);
    wr(TMC_ADDR_LOW0, 8'hFE);
    wr(TMC_ADDR_HIGH0, 8'hFF);
    wr(TMC_ADDR_CONTROL, 8'h10);
    wait_sig(0, 40, n);
    wr(TMC_ADDR_CONTROL, 8'h20);
    rdc("low after wrap", TMC_ADDR_LOW0, 8'h00);
    rdc("high after wrap", TMC_ADDR_HIGH0, 8'h00);
    ack(0);
    #1 chk("flag after ack", 16'h0000, {15'h0000, ovf0});
    // mode 0: prescaler carry into the high byte
    wr(TMC_ADDR_MODE, 8'h00);
    wr(TMC_ADDR_LOW0, 8'h1F);
    wr(TMC_ADDR_HIGH0, 8'hFF);
    wr(TMC_ADDR_CONTROL, 8'h10);
    wait_sig(0, 30, n);
    wr(TMC_ADDR_CONTROL, 8'h00);
    rdc("mode0 high", TMC_ADDR_HIGH0, 8'h00);
    rd(TMC_ADDR_LOW0, d);
    chk("mode0 prescaler", 16'h0000, {11'h000, d[4:0]});
    // counter mode: only falling edges of the pin count
    wr(TMC_ADDR_MODE, 8'h05);
    wr(TMC_ADDR_LOW0, 8'hFD);
    wr(TMC_ADDR_HIGH0, 8'hFF);
    wr(TMC_ADDR_CONTROL, 8'h10);
    for (int p = 0; p < 3; p++) begin
      if (p == 2) rdc("two edges", TMC_ADDR_LOW0, 8'hFF);
      @(posedge sys_clk) cnt0 <= 1'b1;
      repeat (30) @(posedge sys_clk);
      cnt0 <= 1'b0;
      repeat (30) @(posedge sys_clk);
    end
    #1 chk("count flag", 16'h0001, {15'h0000, ovf0});
    wr(TMC_ADDR_CONTROL, 8'h00);
    rdc("three edges", TMC_ADDR_LOW0, 8'h00);
    // timer 1 reload as baud source, across clock speed settings
    wr(TMC_ADDR_MODE, 8'h20);
    wr(TMC_ADDR_LOW1, 8'hFE);
    wr(TMC_ADDR_HIGH1, 8'hFE);
    wr(TMC_ADDR_CONTROL, 8'h40);
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk) dbl <= (i != 0);
      wr(TMC_ADDR_CLKCTL, (i == 2) ? 8'h02 : 8'h00);
      wait_sig(2, 60, n);
      wait_sig(2, 60, n);
      chk("baud gap", (i == 1) ? 16'd12 : 16'd24, 16'(n));
    end
    chk("reload flag", 16'h0001, {15'h0000, ovf1});
    wr(TMC_ADDR_CONTROL, 8'h00);
    rdc("reload source", TMC_ADDR_HIGH1, 8'hFE);
    @(posedge sys_clk) dbl <= 1'b0;
    wr(TMC_ADDR_CLKCTL, 8'h00);
    ack(1);
    // divider sweep: every code, measured on a settled interval
    wr(TMC_ADDR_MODE, 8'h02);
    wr(TMC_ADDR_LOW0, 8'hFF);
    wr(TMC_ADDR_HIGH0, 8'hFF);
    wr(TMC_ADDR_CONTROL, 8'h10);
    for (int c = 0; c < 8; c++) begin
      wr(TMC_ADDR_SCHED, 8'(c));
      repeat (2) begin
        wait_sig(0, 2000, n);
        ack(0);
      end
      wait_sig(0, 2000, n);
      chk("divided gap", 16'(12 << c), 16'(n + 2));
      ack(0);
    end
    wr(TMC_ADDR_CONTROL, 8'h00);
    wr(TMC_ADDR_SCHED, 8'h00);
    // split mode: high half runs on timer 1 run bit, timer 1 held
    wr(TMC_ADDR_MODE, 8'h33);
    wr(TMC_ADDR_LOW1, 8'h10);
    wr(TMC_ADDR_HIGH1, 8'h20);
    wr(TMC_ADDR_LOW0, 8'h00);
    wr(TMC_ADDR_HIGH0, 8'hFE);
    ack(0);
    wr(TMC_ADDR_CONTROL, 8'h40);
    wait_sig(1, 40, n);
    chk("split low flag", 16'h0000, {15'h0000, ovf0});
    wr(TMC_ADDR_CONTROL, 8'h00);
    rdc("split low", TMC_ADDR_LOW0, 8'h00);
    rdc("held low1", TMC_ADDR_LOW1, 8'h10);
    rdc("held high1", TMC_ADDR_HIGH1, 8'h20);
    // timer 1 leaves mode 3 to run with no run bit and no flag
    ack(1);
    wr(TMC_ADDR_LOW1, 8'hFE);
    wr(TMC_ADDR_HIGH1, 8'hFE);
    wr(TMC_ADDR_MODE, 8'h23);
    wait_sig(2, 60, n);
    chk("no flag1", 16'h0000, {15'h0000, ovf1});
    give_verdict();
  end
endmodule // tmc_timer_pair_tb
